// ---- verilog/sft_map.svh ----
// Constants for the supply fault threshold logic: counts, limits, range table, reset values.
`ifndef SFT_MAP_SVH
`define SFT_MAP_SVH

// ----------------------------------------------------------------------------
// Channel counts
// ----------------------------------------------------------------------------
`define SFT_NUM_CH 10
`define SFT_NUM_DED 5
`define SFT_NUM_DUAL 5
`define SFT_CHAN_W 4

// ----------------------------------------------------------------------------
// Code limits
// ----------------------------------------------------------------------------
`define SFT_CODE_MAX 8'hFF
`define SFT_CODE_MIN 8'h00
`define SFT_HYST_MAX 5'h1F
`define SFT_CODE_DIV 32'h000000FF

// ----------------------------------------------------------------------------
// Range table in microvolts: bottom and span of each range
// ----------------------------------------------------------------------------
`define SFT_R0_BOT_UV 32'h0008BE48
`define SFT_R0_SPAN_UV 32'h000C3CD0
`define SFT_R1_BOT_UV 32'h001312D0
`define SFT_R1_SPAN_UV 32'h001AB3F0
`define SFT_R2_BOT_UV 32'h002625A0
`define SFT_R2_SPAN_UV 32'h003567E0
`define SFT_R3_BOT_UV 32'h005B8D80
`define SFT_R3_SPAN_UV 32'h00802C80

// ----------------------------------------------------------------------------
// Reset values and the fixed range of the dual channels
// ----------------------------------------------------------------------------
`define SFT_RST_CODE 8'h00
`define SFT_RST_HYST 5'h00
`define SFT_RST_RANGE 2'h0
`define SFT_DUAL_RANGE 2'h0

`endif

// ---- verilog/sft_pkg.sv ----
// Types shared by the supply fault threshold logic.
package sft_pkg;

    // Fault condition that a detector channel flags.
    typedef enum logic [1:0] {
        MODE_UNDER,
        MODE_OVER,
        MODE_WINDOW
    } sft_mode_type;

    typedef logic [1:0] sft_range_type;

    // Per-channel settings written by software.
    typedef struct packed {
        logic [7:0] uv_code;
        logic [7:0] ov_code;
        logic [4:0] hyst_code;
        sft_range_type range_sel;
        sft_mode_type mode;
        logic analog_en;
    } sft_chan_cfg_type;

    // Per-channel detector state and comparator reference codes.
    typedef struct packed {
        logic uv_flt;
        logic ov_flt;
        logic flt;
        logic [7:0] uv_ref;
        logic [7:0] ov_ref;
    } sft_chan_stat_type;

endpackage

// ---- verilog/sft_channel.sv ----
// One supply fault detector channel: fault latches and hysteresis-shifted references.
`timescale 1ns/10ps
`include "sft_map.svh"

module sft_channel (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic det_en_i,
    input sft_pkg::sft_chan_cfg_type cfg_i,
    input wire logic uv_below_i,
    input wire logic ov_above_i,
    output sft_pkg::sft_chan_stat_type stat_o
);
    import sft_pkg::*;

    sft_chan_stat_type stat_ff;
    sft_chan_stat_type nxt_stat;
    logic uv_on;
    logic ov_on;
    logic [8:0] uv_sum;

    // ------------------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------------------
    always_comb begin
        uv_on = det_en_i && (cfg_i.mode != MODE_OVER); // RULE3
        ov_on = det_en_i && (cfg_i.mode != MODE_UNDER); // RULE3
        uv_sum = {1'b0, cfg_i.uv_code} + {4'h0, cfg_i.hyst_code};
        nxt_stat = stat_ff;
        // The comparators already see the shifted reference while a fault stands,
        // so a comparator still active means the release level is not yet reached.
        nxt_stat.uv_flt = uv_on && uv_below_i; // RULE8
        nxt_stat.ov_flt = ov_on && ov_above_i; // RULE9
        nxt_stat.flt = nxt_stat.uv_flt || nxt_stat.ov_flt; // RULE11
        // Hysteresis is in the same step units as the threshold code.
        if (nxt_stat.uv_flt) begin
            nxt_stat.uv_ref = uv_sum[8] ? `SFT_CODE_MAX : uv_sum[7:0]; // RULE8 RULE10
        end else begin
            nxt_stat.uv_ref = cfg_i.uv_code; // RULE7
        end
        if (nxt_stat.ov_flt && (cfg_i.ov_code >= {3'h0, cfg_i.hyst_code})) begin
            nxt_stat.ov_ref = cfg_i.ov_code - {3'h0, cfg_i.hyst_code}; // RULE9 RULE10
        end else if (nxt_stat.ov_flt) begin
            nxt_stat.ov_ref = `SFT_CODE_MIN;
        end else begin
            nxt_stat.ov_ref = cfg_i.ov_code; // RULE7
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign stat_o = stat_ff;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_uv_fault_set: assert property (uv_on && uv_below_i |=> stat_ff.uv_flt) // RULE3
        else $error("Undervoltage fault not set.");
    a_uv_fault_release: assert property (stat_ff.uv_flt && !uv_below_i |=> !stat_ff.uv_flt) // RULE8
        else $error("Undervoltage fault not released.");
    a_ov_fault_release: assert property (stat_ff.ov_flt && !ov_above_i |=> !stat_ff.ov_flt) // RULE9
        else $error("Overvoltage fault not released.");
    a_window_or_flag: assert property (stat_ff.flt == (stat_ff.uv_flt || stat_ff.ov_flt)) // RULE11
        else $error("Channel flag differs from the OR of its conditions.");
    a_bare_uv_ref: assert property (!stat_ff.uv_flt |-> stat_ff.uv_ref == $past(cfg_i.uv_code)) // RULE7
        else $error("Undervoltage reference shifted while in tolerance.");
    a_bare_ov_ref: assert property (!stat_ff.ov_flt |-> stat_ff.ov_ref == $past(cfg_i.ov_code)) // RULE7
        else $error("Overvoltage reference shifted while in tolerance.");
    a_uv_hyst_ref: assert property ($rose(stat_ff.uv_flt) |-> // RULE8
        ({1'b0, $past(cfg_i.uv_code)} + {4'h0, $past(cfg_i.hyst_code)} > 9'h0FF) ?
        (stat_ff.uv_ref == `SFT_CODE_MAX) :
        ({1'b0, stat_ff.uv_ref} == {1'b0, $past(cfg_i.uv_code)} + {4'h0, $past(cfg_i.hyst_code)}))
        else $error("Undervoltage release level is not threshold plus hysteresis.");
    a_ov_hyst_ref: assert property ($rose(stat_ff.ov_flt) |-> // RULE9
        ($past(cfg_i.ov_code) < {3'h0, $past(cfg_i.hyst_code)}) ?
        (stat_ff.ov_ref == `SFT_CODE_MIN) :
        (stat_ff.ov_ref + {3'h0, $past(cfg_i.hyst_code)} == $past(cfg_i.ov_code)))
        else $error("Overvoltage release level is not threshold minus hysteresis.");
    a_disabled_quiet: assert property (!det_en_i |=> !stat_ff.uv_flt && !stat_ff.ov_flt) // RULE2
        else $error("Disabled detector raised a fault.");

    c_uv_fault: cover property ($rose(stat_ff.uv_flt));
    c_ov_fault: cover property ($rose(stat_ff.ov_flt));
    c_window_fault: cover property (cfg_i.mode == MODE_WINDOW && $rose(stat_ff.flt));

endmodule // sft_channel

// ---- verilog/sft_supply_fault.sv ----
// Top of the supply fault threshold logic: settings, channel detectors, readback.
// ----------------------------------------------------------------------------
// Overview of operation
// [RULE1] Five dedicated plus five dual-function channels.
// [RULE2] Analog dual channel gives no logic input.
// [RULE3] Modes: undervoltage, overvoltage, or out-of-window.
// [RULE4] Eight-bit threshold codes per channel.
// [RULE5] Threshold is bottom plus span times code/255.
// [RULE6] Four ranges with fixed bottom and span.
// [RULE7] In tolerance, compare against bare threshold.
// [RULE8] Undervoltage holds until threshold plus hysteresis.
// [RULE9] Overvoltage holds until threshold minus hysteresis.
// [RULE10] Five-bit hysteresis code, span times code over 255.
// [RULE11] Window flag ORs both conditions independently.
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`include "sft_map.svh"

module sft_supply_fault (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic cfg_wr_i,
    input wire logic [3:0] cfg_chan_i,
    input sft_pkg::sft_chan_cfg_type cfg_i,
    input wire logic [9:0] uv_below_i,
    input wire logic [9:0] ov_above_i,
    input wire logic [4:0] dual_level_i,
    input wire logic [3:0] mon_chan_i,
    output sft_pkg::sft_chan_stat_type [9:0] stat_o,
    output sft_pkg::sft_range_type [9:0] range_o,
    output logic [9:0] det_en_o,
    output logic [4:0] logic_in_o,
    output logic fault_any_o,
    output logic [31:0] mon_uv_th_o,
    output logic [31:0] mon_ov_th_o,
    output logic [31:0] mon_hyst_o
);
    import sft_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        sft_chan_cfg_type [9:0] cfg;
        sft_range_type [9:0] rng;
        logic [9:0] det_en;
        logic [4:0] logic_in;
        logic fault_any;
        logic [31:0] mon_uv_th;
        logic [31:0] mon_ov_th;
        logic [31:0] mon_hyst;
    } sft_top_state_type;

    sft_top_state_type state_ff;
    sft_top_state_type nxt_state;
    sft_chan_stat_type [9:0] chan_stat;
    sft_chan_cfg_type mon_cfg;
    logic [9:0] any_vec;

    // ------------------------------------------------------------------------
    // Range table lookup
    // ------------------------------------------------------------------------
    function automatic logic [31:0] range_bottom(input sft_range_type rs);
        logic [31:0] v;
        case (rs)
            2'h0: v = `SFT_R0_BOT_UV;
            2'h1: v = `SFT_R1_BOT_UV;
            2'h2: v = `SFT_R2_BOT_UV;
            default: v = `SFT_R3_BOT_UV;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] range_span(input sft_range_type rs);
        logic [31:0] v;
        case (rs)
            2'h0: v = `SFT_R0_SPAN_UV;
            2'h1: v = `SFT_R1_SPAN_UV;
            2'h2: v = `SFT_R2_SPAN_UV;
            default: v = `SFT_R3_SPAN_UV;
        endcase
        return v;
    endfunction

    // Largest product is 8.4 V span times 255, which still fits in 32 bits.
    function automatic logic [31:0] code_volts(input sft_range_type rs, input logic [7:0] code);
        logic [31:0] prod;
        prod = range_span(rs) * {24'h0, code};
        return range_bottom(rs) + prod / `SFT_CODE_DIV; // RULE5
    endfunction

    function automatic logic [31:0] hyst_volts(input sft_range_type rs, input logic [4:0] code);
        logic [31:0] prod;
        prod = range_span(rs) * {27'h0, code};
        return prod / `SFT_CODE_DIV; // RULE10
    endfunction

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (cfg_wr_i && (cfg_chan_i < `SFT_CHAN_W'(`SFT_NUM_CH))) begin
            nxt_state.cfg[cfg_chan_i] = cfg_i; // RULE4
        end
        for (int i = 0; i < `SFT_NUM_CH; i++) begin
            if (i < `SFT_NUM_DED) begin
                // Dedicated channels are always detectors and may use any range.
                nxt_state.det_en[i] = 1'b1; // RULE1
                nxt_state.rng[i] = state_ff.cfg[i].range_sel; // RULE6
            end else begin
                // The high-impedance pins have a single range only.
                nxt_state.det_en[i] = state_ff.cfg[i].analog_en; // RULE1
                nxt_state.rng[i] = `SFT_DUAL_RANGE; // RULE6
            end
        end
        for (int j = 0; j < `SFT_NUM_DUAL; j++) begin
            if (state_ff.cfg[j + `SFT_NUM_DED].analog_en) begin
                nxt_state.logic_in[j] = 1'b0; // RULE2
            end else begin
                nxt_state.logic_in[j] = dual_level_i[j]; // RULE2
            end
        end
        nxt_state.fault_any = |any_vec;
        // Readback shows what the programmed codes mean in microvolts.
        // The stored range lags a settings write by one cycle, so the readback
        // is only trustworthy from the second edge after the write.
        nxt_state.mon_uv_th = code_volts(state_ff.rng[mon_chan_i], mon_cfg.uv_code); // RULE5
        nxt_state.mon_ov_th = code_volts(state_ff.rng[mon_chan_i], mon_cfg.ov_code); // RULE5
        nxt_state.mon_hyst = hyst_volts(state_ff.rng[mon_chan_i], mon_cfg.hyst_code); // RULE10
        if (mon_chan_i >= `SFT_CHAN_W'(`SFT_NUM_CH)) begin
            nxt_state.mon_uv_th = 32'h00000000;
            nxt_state.mon_ov_th = 32'h00000000;
            nxt_state.mon_hyst = 32'h00000000;
        end
    end

    always_comb begin
        if (mon_chan_i < `SFT_CHAN_W'(`SFT_NUM_CH)) begin
            mon_cfg = state_ff.cfg[mon_chan_i];
        end else begin
            mon_cfg = '0;
        end
    end

    // Settings return to zero on reset, so every dedicated channel starts as an
    // undervoltage detector at the range bottom with no hysteresis; dual channels start with detection off.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------------
    // Detector channels
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SFT_NUM_CH; g++) begin : g_chan
            sft_channel u_chan (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .det_en_i(state_ff.det_en[g]),
                .cfg_i(state_ff.cfg[g]),
                .uv_below_i(uv_below_i[g]),
                .ov_above_i(ov_above_i[g]),
                .stat_o(chan_stat[g])
            );
            assign any_vec[g] = chan_stat[g].flt;
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign stat_o = chan_stat;
    assign range_o = state_ff.rng;
    assign det_en_o = state_ff.det_en;
    assign logic_in_o = state_ff.logic_in;
    assign fault_any_o = state_ff.fault_any;
    assign mon_uv_th_o = state_ff.mon_uv_th;
    assign mon_ov_th_o = state_ff.mon_ov_th;
    assign mon_hyst_o = state_ff.mon_hyst;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // The first edge after release still shows the reset value, so it is skipped.
    a_dedicated_always_on: assert property ( // RULE1
        !$past(srst_i) |-> det_en_o[4:0] == 5'h1F)
        else $error("Dedicated detector disabled.");
    a_cfg_write: assert property ( // RULE4
        cfg_wr_i && cfg_chan_i < 4'hA |=> state_ff.cfg[$past(cfg_chan_i)] == $past(cfg_i))
        else $error("Channel settings write did not land.");
    // The summary flag needs one edge out of reset before it can follow the channels.
    a_fault_any_or: assert property ( // RULE3
        !$past(srst_i) |-> fault_any_o == $past(|any_vec))
        else $error("Summary fault flag differs from the channel flags.");
    a_analog_no_logic: assert property (
        state_ff.cfg[5].analog_en |=> logic_in_o[0] == 1'b0) // RULE2
        else $error("Analog dual channel still passes a logic level.");
    a_dual_range_fixed: assert property (range_o[9:5] == 10'h000) // RULE6
        else $error("Dual-function channel left its single range.");
    a_code_bottom: assert property (
        mon_chan_i < 4'hA && mon_cfg.uv_code == 8'h00 |=>
        mon_uv_th_o == range_bottom($past(state_ff.rng[mon_chan_i]))) // RULE5
        else $error("Code zero does not map to range bottom.");
    a_code_top: assert property (
        mon_chan_i < 4'hA && mon_cfg.ov_code == 8'hFF |=>
        mon_ov_th_o == range_bottom($past(state_ff.rng[mon_chan_i]))
            + range_span($past(state_ff.rng[mon_chan_i]))) // RULE5
        else $error("Code 255 does not map to range top.");

    c_all_analog: cover property (det_en_o == 10'h3FF);
    c_logic_pass: cover property (|logic_in_o);

endmodule // sft_supply_fault

// ---- verif/sft_rail_model.sv ----
// Comparator model of the monitored rails seen through the detector reference codes.
`timescale 1ns/10ps

module sft_rail_model (
    input sft_pkg::sft_chan_stat_type [9:0] stat_i,
    input sft_pkg::sft_range_type [9:0] range_i,
    input wire logic [9:0][31:0] rail_uv_i,
    output logic [9:0] uv_below_o,
    output logic [9:0] ov_above_o
);
    import sft_pkg::*;

    // ------------------------------------------------------------------------
    // Threshold in microvolts for a range and a code
    // ------------------------------------------------------------------------
    function automatic logic [31:0] thr(input logic [1:0] rg, input logic [7:0] code);
        logic [63:0] pair;
        case (rg)
            2'h0: pair = 64'h0008BE48_000C3CD0;
            2'h1: pair = 64'h001312D0_001AB3F0;
            2'h2: pair = 64'h002625A0_003567E0;
            default: pair = 64'h005B8D80_00802C80;
        endcase
        thr = pair[63:32] + pair[31:0] * {24'h000000, code} / 32'h000000FF;
    endfunction

    // ------------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------------
    // Strict compares: a rail exactly on the threshold counts as in tolerance.
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            uv_below_o[i] = rail_uv_i[i] < thr(range_i[i], stat_i[i].uv_ref);
            ov_above_o[i] = rail_uv_i[i] > thr(range_i[i], stat_i[i].ov_ref);
        end
    end
endmodule // sft_rail_model

// ---- verif/test_sft_supply_fault.sv ----
// Self-checking testbench for the supply fault threshold logic.
`timescale 1ns/10ps

module test_sft_supply_fault;
    import sft_pkg::*;

    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic cfg_wr_i = 1'b0;
    logic [3:0] cfg_chan_i = 4'h0;
    sft_chan_cfg_type cfg_i = '0;
    logic [4:0] dual_level_i = 5'h15;
    logic [3:0] mon_chan_i = 4'h0;
    logic [9:0][31:0] rail_uv = {10{32'h000F4240}};
    logic [9:0] uv_below;
    logic [9:0] ov_above;
    sft_chan_stat_type [9:0] stat;
    sft_range_type [9:0] range;
    logic [9:0] det_en;
    logic [4:0] logic_in;
    logic fault_any;
    logic [31:0] mon_uv;
    logic [31:0] mon_ov;
    logic [31:0] mon_hy;
    int failures = 0;
    int cmp_count = 0;

    always #5 clk_i = ~clk_i;

    sft_supply_fault dut (.clk_i(clk_i), .srst_i(srst_i), .cfg_wr_i(cfg_wr_i),
        .cfg_chan_i(cfg_chan_i), .cfg_i(cfg_i), .uv_below_i(uv_below), .ov_above_i(ov_above),
        .dual_level_i(dual_level_i), .mon_chan_i(mon_chan_i), .stat_o(stat), .range_o(range),
        .det_en_o(det_en), .logic_in_o(logic_in), .fault_any_o(fault_any),
        .mon_uv_th_o(mon_uv), .mon_ov_th_o(mon_ov), .mon_hyst_o(mon_hy));

    sft_rail_model rail (.stat_i(stat), .range_i(range), .rail_uv_i(rail_uv),
        .uv_below_o(uv_below), .ov_above_o(ov_above));

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic run(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Stores come out two edges after the write edge, so the task waits them out.
    task automatic wr(input logic [3:0] ch, input sft_chan_cfg_type c);
        cfg_chan_i = ch;
        cfg_i = c;
        cfg_wr_i = 1'b1;
        run(1);
        cfg_wr_i = 1'b0;
        run(2);
    endtask

    function automatic sft_chan_cfg_type mk(logic [7:0] uv, logic [7:0] ov, logic [4:0] hy,
        logic [1:0] rg, sft_mode_type md);
        mk = '{uv, ov, hy, rg, md, 1'b1};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        run(2);
        chk("det_en", 32'(det_en), 32'h0000001F);
        chk("logic_in", 32'(logic_in), 32'h00000015);
        $display("test reset done");

        rail_uv[0] = rail.thr(2'h2, 8'hB6) + 32'h00000001;
        wr(4'h0, mk(8'hB6, 8'hFF, 5'h0A, 2'h2, MODE_UNDER));
        chk("range0", 32'(range[0]), 32'h00000002);
        chk("mon_uv", mon_uv, rail.thr(2'h2, 8'hB6));
        chk("mon_hy", mon_hy, 32'h003567E0 * 32'h0000000A / 32'h000000FF);
        chk("uv0 in", 32'(stat[0].uv_flt), 32'h00000000);
        rail_uv[0] = rail.thr(2'h2, 8'hB6) - 32'h00000001;
        run(3);
        chk("uv0 set", 32'(stat[0].uv_flt), 32'h00000001);
        chk("uv_ref0", 32'(stat[0].uv_ref), 32'h000000C0);
        chk("any set", 32'(fault_any), 32'h00000001);
        rail_uv[0] = rail.thr(2'h2, 8'hB6) + 32'h00000001;
        run(3);
        chk("uv0 hold", 32'(stat[0].uv_flt), 32'h00000001);
        rail_uv[0] = rail.thr(2'h2, 8'hC0) + 32'h00000001;
        run(3);
        chk("uv0 clr", 32'(stat[0].flt), 32'h00000000);
        chk("uv_ref0 b", 32'(stat[0].uv_ref), 32'h000000B6);
        $display("test undervoltage done");

        wr(4'h1, mk(8'h00, 8'h80, 5'h1F, 2'h1, MODE_OVER));
        rail_uv[1] = rail.thr(2'h1, 8'h80) + 32'h00000001;
        run(3);
        chk("ov1 set", 32'(stat[1].ov_flt), 32'h00000001);
        chk("ov_ref1", 32'(stat[1].ov_ref), 32'h00000061);
        rail_uv[1] = rail.thr(2'h1, 8'h80) - 32'h00000001;
        run(3);
        chk("ov1 hold", 32'(stat[1].ov_flt), 32'h00000001);
        rail_uv[1] = 32'h00000000;
        run(3);
        chk("ov1 clr", 32'(stat[1].flt), 32'h00000000);
        chk("uv1 off", 32'(stat[1].uv_flt), 32'h00000000);
        $display("test overvoltage done");

        chk("dual off", 32'(stat[6].flt), 32'h00000000);
        wr(4'h5, mk(8'h40, 8'hC0, 5'h05, 2'h3, MODE_WINDOW));
        chk("range5", 32'(range[5]), 32'h00000000);
        chk("det_en5", 32'(det_en[5]), 32'h00000001);
        chk("logic5", 32'(logic_in[0]), 32'h00000000);
        rail_uv[5] = rail.thr(2'h0, 8'h40) - 32'h00000001;
        run(3);
        chk("win low", 32'({stat[5].uv_flt, stat[5].flt}), 32'h00000003);
        rail_uv[5] = rail.thr(2'h0, 8'hC0) + 32'h00000001;
        run(3);
        chk("win high", 32'({stat[5].uv_flt, stat[5].ov_flt, stat[5].flt}), 32'h00000003);
        rail_uv[5] = rail.thr(2'h0, 8'h80);
        run(3);
        chk("win mid", 32'(stat[5].flt), 32'h00000000);
        chk("any clr", 32'(fault_any), 32'h00000000);
        $display("test window done");

        wr(4'h2, mk(8'hF0, 8'h00, 5'h1F, 2'h3, MODE_UNDER));
        mon_chan_i = 4'h2;
        run(3);
        chk("uv_ref2 sat", 32'(stat[2].uv_ref), 32'h000000FF);
        chk("mon_hy2", mon_hy, 32'h00802C80 * 32'h0000001F / 32'h000000FF);
        chk("mon_ov2", mon_ov, 32'h005B8D80);
        $display("test saturation done");

        srst_i = 1'b1;
        run(2);
        chk("rst det_en", 32'(det_en), 32'h00000000);
        chk("rst stat2", 32'(stat[2]), 32'h00000000);
        srst_i = 1'b0;
        run(2);
        chk("det_en again", 32'(det_en), 32'h0000001F);
        chk("uv1 after rst", 32'(stat[1].uv_flt), 32'h00000001);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule // test_sft_supply_fault
